//--- acs_pkg.sv
/*
 * Shared constants for the conversion sequencer: register offsets, field
 * positions, reset values and the delay tick timing.
 * Assumes a 250 MHz system clock and a 32-bit classic Wishbone bus.
 */
package acs_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CONTROL   = 8'h00; // Converter control.
    localparam logic [7:0] OFF_DELAY     = 8'h04; // Conversion delays.
    localparam logic [7:0] OFF_ONESHOT   = 8'h0C; // One-shot channel mask.
    localparam logic [7:0] OFF_PERIODIC  = 8'h10; // Periodic channel mask.
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h40; // Event status, read clears.
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h44; // Event interrupt mask.

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTL_ON      = 0; // Converter on.
    localparam int CTL_ONESHOT = 1; // One-shot run, self clearing.
    localparam int CTL_PERIOD  = 2; // Periodic run.
    localparam int CTL_PDDIS   = 3; // Idle power-down disable.
    localparam int CTL_HWRST   = 4; // Block hardware reset.
    localparam int CTL_PDONE   = 6; // Periodic complete flag.
    localparam int CTL_ODONE   = 7; // One-shot complete flag.

    // Delay register fields: interval high, first-cycle wait low.
    localparam int DLY_IVL_LSB   = 16;
    localparam int DLY_FIRST_LSB = 0;

    // Event status and mask layout.
    localparam int EVT_ODONE = 0;
    localparam int EVT_PDONE = 1;
    localparam int EVT_W     = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [31:0] RST_DELAY   = 32'h0000_0000;
    localparam logic [15:0] RST_MASK    = 16'h0000;
    localparam logic [1:0]  RST_EVT     = 2'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;     // System clock period.
    localparam int TICK_TIME_NS  = 40000;    // Delay step, 40 us.
    localparam int TICK_CYCLES   = (TICK_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int CHANNELS      = 16;       // Channels per mask.

endpackage

//--- acs_tmr_if.sv
/*
 * Bundle between the sequencer and its delay timer.
 * Assumes both ends run on the same system clock.
 */
interface acs_tmr_if;
    logic        load;    // Start counting value ticks.
    logic [15:0] value;   // Delay in ticks.
    logic        clear;   // Stop and forget any count.
    logic        expired; // One-cycle pulse when the count ends.

    modport ctl (output load, output value, output clear, input expired);
    modport tmr (input load, input value, input clear, output expired);
endinterface

//--- acs_delay_timer.sv
/*
 * Delay timer: a prescaler giving one tick per step and a sixteen-bit
 * down counter of steps.
 * Assumes load is a single-cycle strobe from the sequencer; clear stays high through the block reset.
 */
module acs_delay_timer #(
    parameter int TICK_CYCLES = acs_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    acs_tmr_if.tmr    tmr
);

    // ****************************************************************
    // Prescaler and step counter
    // ****************************************************************
    localparam int PW = $clog2(TICK_CYCLES + 1);

    logic [PW-1:0] pre;    // Cycles into the current step.
    logic [15:0]   steps;  // Steps still to wait.
    logic          active; // A delay is running.
    logic          tick;   // One-cycle step marker.

    // The prescaler restarts on load so a delay is exact in cycles.
    assign tick = (pre == PW'(TICK_CYCLES - 1));

    // Prescaler, running only while a delay is active.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pre <= '0;
        else if (tmr.clear || tmr.load || !active || tick)
            pre <= '0;
        else
            pre <= pre + PW'(1);
    end

    // Step counter; a zero load expires on the following cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            steps       <= '0;
            active      <= 1'b0;
            tmr.expired <= 1'b0;
        end
        else
        begin
            tmr.expired <= 1'b0;
            if (tmr.clear)
                active <= 1'b0;
            else if (tmr.load)
            begin
                steps  <= tmr.value;
                active <= 1'b1;
            end
            else if (active && steps == 16'h0000)
            begin
                active      <= 1'b0;
                tmr.expired <= 1'b1;
            end
            else if (active && tick)
                steps <= steps - 16'h0001;
        end
    end

endmodule

//--- acs_sequencer.sv
/*
 * Conversion sequencer for a sixteen-channel converter core: control and
 * delay registers, channel masks, one-shot and periodic cycles, power
 * control of the core and a maskable completion interrupt.
 * Assumes a classic Wishbone master on MCLK and a core that answers each
 * start strobe with one CORE_DONE pulse.
 */

module acs_sequencer #(
    parameter int TICK_CYCLES = acs_pkg::TICK_CYCLES
) (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ,
    output logic             CORE_RESET,
    output logic             CORE_POWER,
    output logic             CORE_START,
    output logic      [3:0]  CORE_CHANNEL,
    input  wire logic        CORE_DONE
);

    // ****************************************************************
    // Elaboration checks and types
    // ****************************************************************
    if (TICK_CYCLES < 2)
        $error("TICK_CYCLES must be at least 2");

    // One-hot sequencer states.
    typedef enum logic [2:0] {
        ACS_IDLE  = 3'h1,  // No cycle running.
        ACS_ISSUE = 3'h2,  // Strobe the next channel.
        ACS_WAIT  = 3'h4   // Wait for the core to finish it.
    } acs_state_t;

    // Byte-lane merge of a write into a register.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[i*8 +: 8] = wdat[i*8 +: 8];
        return r;
    endfunction

    // Index of the lowest set bit of a channel mask.
    function automatic logic [3:0] lowest(input logic [15:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--)
            if (m[i])
                r = 4'(i);
        return r;
    endfunction

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    logic [7:0]       ctrl;        // Control register bits 7:0.
    logic [31:0]      delay;       // Interval and first-cycle wait.
    logic [15:0]      oneshot_mask;          // One-shot channels.
    logic [15:0]      periodic_channel_mask; // Periodic channels.
    logic [1:0]       evt_stat;    // Sticky events, read clears.
    logic [1:0]       evt_mask;    // Events that reach IRQ.
    logic             on_q;        // Converter on, one cycle late.
    logic             periodic_due; // Timer ran out, cycle owed.
    acs_state_t       state;       // Sequencer state.
    logic [15:0]      work;        // Channels left in this cycle.
    logic             kind_periodic; // Running cycle is periodic.

    // Bus decode.
    logic             req;         // A bus request is waiting.
    logic             wr;          // A write takes effect this edge.
    logic             rd_done;     // A read completes this edge.
    logic [31:0]      rdat;        // Read data for this address.
    logic [31:0]      ctrl_new;    // Control after byte merge.

    // Sequencer controls.
    logic             hw_rst;      // Block hardware reset.
    logic             launch_one;  // One-shot cycle begins.
    logic             launch_per;  // Periodic cycle begins.
    logic             cycle_end;   // Last channel finished.
    logic             per_rise;    // Periodic run written 0 to 1.
    logic             per_fall;    // Periodic run written 1 to 0.

    acs_tmr_if tmr_bus ();

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    // Every request is answered one cycle after it is seen, so the
    // access lands at the edge where the master samples ack high.
    assign req      = WB_CYC_I && WB_STB_I;
    assign wr       = req && WB_ACK_O && WB_WE_I;
    assign rd_done  = req && WB_ACK_O && !WB_WE_I;
    assign ctrl_new = merge({24'h0, ctrl}, WB_DAT_I, WB_SEL_I);

    // Ack pulses once per request and drops the cycle after.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            WB_ACK_O <= 1'b0;
        else
            WB_ACK_O <= req && !WB_ACK_O;
    end

    // Read mux; unmapped offsets read as zero.
    always_comb
    begin
        unique case (WB_ADR_I)
            acs_pkg::OFF_CONTROL:  rdat = {24'h0, ctrl};
            acs_pkg::OFF_DELAY:    rdat = delay;
            acs_pkg::OFF_ONESHOT:  rdat = {16'h0, oneshot_mask};
            acs_pkg::OFF_PERIODIC: rdat = {16'h0, periodic_channel_mask};
            acs_pkg::OFF_IRQ_STAT: rdat = {30'h0, evt_stat};
            acs_pkg::OFF_IRQ_MASK: rdat = {30'h0, evt_mask};
            default:               rdat = 32'h0000_0000;
        endcase
    end

    // Read data is captured while the request waits for its ack.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            WB_DAT_O <= 32'h0000_0000;
        else if (req && !WB_ACK_O)
            WB_DAT_O <= rdat;
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    assign hw_rst   = ctrl[acs_pkg::CTL_HWRST];
    assign per_rise = wr && WB_ADR_I == acs_pkg::OFF_CONTROL
                      && ctrl_new[acs_pkg::CTL_PERIOD]
                      && !ctrl[acs_pkg::CTL_PERIOD];
    assign per_fall = wr && WB_ADR_I == acs_pkg::OFF_CONTROL
                      && !ctrl_new[acs_pkg::CTL_PERIOD]
                      && ctrl[acs_pkg::CTL_PERIOD];

    // Plain bits follow writes; done flags are write-one-to-clear and a
    // completion in the same edge wins over the clear.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            ctrl <= acs_pkg::RST_CONTROL;
        else
        begin
            if (wr && WB_ADR_I == acs_pkg::OFF_CONTROL)
            begin
                ctrl[acs_pkg::CTL_ON]     <= ctrl_new[acs_pkg::CTL_ON];
                ctrl[acs_pkg::CTL_PERIOD] <= ctrl_new[acs_pkg::CTL_PERIOD];
                ctrl[acs_pkg::CTL_PDDIS]  <= ctrl_new[acs_pkg::CTL_PDDIS];
                ctrl[acs_pkg::CTL_HWRST]  <= ctrl_new[acs_pkg::CTL_HWRST];
                if (ctrl_new[acs_pkg::CTL_ONESHOT])
                    ctrl[acs_pkg::CTL_ONESHOT] <= 1'b1;
                if (ctrl_new[acs_pkg::CTL_ODONE])
                    ctrl[acs_pkg::CTL_ODONE] <= 1'b0;
                if (ctrl_new[acs_pkg::CTL_PDONE])
                    ctrl[acs_pkg::CTL_PDONE] <= 1'b0;
            end
            // The run request is dropped once taken; writing zero is
            // never needed.
            if (launch_one)
                ctrl[acs_pkg::CTL_ONESHOT] <= 1'b0;
            if (cycle_end && !kind_periodic)
                ctrl[acs_pkg::CTL_ODONE] <= 1'b1;
            if (cycle_end && kind_periodic)
                ctrl[acs_pkg::CTL_PDONE] <= 1'b1;
        end
    end

    // ****************************************************************
    // Delay, mask and interrupt registers
    // ****************************************************************
    // Software registers survive the block hardware reset untouched.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            delay                 <= acs_pkg::RST_DELAY;
            oneshot_mask          <= acs_pkg::RST_MASK;
            periodic_channel_mask <= acs_pkg::RST_MASK;
            evt_mask              <= acs_pkg::RST_EVT;
        end
        else if (wr)
        begin
            unique case (WB_ADR_I)
                acs_pkg::OFF_DELAY:
                    delay <= merge(delay, WB_DAT_I, WB_SEL_I);
                acs_pkg::OFF_ONESHOT:
                    oneshot_mask <= 16'(merge({16'h0, oneshot_mask},
                                              WB_DAT_I, WB_SEL_I));
                acs_pkg::OFF_PERIODIC:
                    periodic_channel_mask <= 16'(merge(
                        {16'h0, periodic_channel_mask}, WB_DAT_I, WB_SEL_I));
                acs_pkg::OFF_IRQ_MASK:
                    evt_mask <= WB_DAT_I[acs_pkg::EVT_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // Sticky events: a read clears only the bits it returned, so an event
    // landing after the read data was captured survives; a set wins.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            evt_stat <= acs_pkg::RST_EVT;
        else
        begin
            if (rd_done && WB_ADR_I == acs_pkg::OFF_IRQ_STAT)
                evt_stat <= evt_stat & ~WB_DAT_O[acs_pkg::EVT_W-1:0];
            if (cycle_end && !kind_periodic)
                evt_stat[acs_pkg::EVT_ODONE] <= 1'b1;
            if (cycle_end && kind_periodic)
                evt_stat[acs_pkg::EVT_PDONE] <= 1'b1;
        end
    end

    assign IRQ = |(evt_stat & evt_mask);

    // ****************************************************************
    // Core reset
    // ****************************************************************
    // Converter-on history for the rising-edge reset pulse.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            on_q <= 1'b0;
        else
            on_q <= ctrl[acs_pkg::CTL_ON];
    end

    // The core is held in reset for the whole block reset, and pulsed for
    // one cycle when the converter is switched on.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            CORE_RESET <= 1'b0;
        else
            CORE_RESET <= hw_rst
                || (ctrl[acs_pkg::CTL_ON] && !on_q);
    end

    // ****************************************************************
    // Periodic delay timing
    // ****************************************************************
    acs_delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .clk   (MCLK),
        .rst_n (RSTN),
        .tmr   (tmr_bus.tmr)
    );

    // The first periodic cycle waits the first-cycle count, each later
    // one the interval, counted from the end of the previous cycle.
    assign tmr_bus.load  = per_rise
        || (cycle_end && kind_periodic && ctrl[acs_pkg::CTL_PERIOD]);
    assign tmr_bus.value = per_rise
        ? delay[acs_pkg::DLY_FIRST_LSB +: 16]
        : delay[acs_pkg::DLY_IVL_LSB +: 16];
    assign tmr_bus.clear = per_fall || hw_rst;

    // A finished delay owes one periodic cycle; stopping periodic run or
    // the block reset forgets it.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            periodic_due <= 1'b0;
        else if (hw_rst || per_fall)
            periodic_due <= 1'b0;
        else if (tmr_bus.expired && ctrl[acs_pkg::CTL_PERIOD])
            periodic_due <= 1'b1;
        else if (launch_per)
            periodic_due <= 1'b0;
    end

    // ****************************************************************
    // Channel scan
    // ****************************************************************
    // One-shot takes priority and never waits on a delay; nothing starts
    // while the converter is off or the block is held in reset.
    assign launch_one = state == ACS_IDLE && !hw_rst
                        && ctrl[acs_pkg::CTL_ON]
                        && ctrl[acs_pkg::CTL_ONESHOT];
    assign launch_per = state == ACS_IDLE && !hw_rst && !launch_one
                        && ctrl[acs_pkg::CTL_ON]
                        && ctrl[acs_pkg::CTL_PERIOD]
                        && periodic_due;
    // A cycle ends when its last channel reports, or at once if its mask
    // was empty.
    assign cycle_end  = !hw_rst && (
        (state == ACS_WAIT && CORE_DONE && (work & ~(16'h1 << CORE_CHANNEL))
            == 16'h0000)
        || (state == ACS_ISSUE && work == 16'h0000));

    // Scan state; a cycle in progress runs on after the converter or the
    // periodic run is switched off.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state         <= ACS_IDLE;
            work          <= 16'h0000;
            kind_periodic <= 1'b0;
            CORE_CHANNEL  <= 4'h0;
        end
        else if (hw_rst)
        begin
            state <= ACS_IDLE;
            work  <= 16'h0000;
        end
        else
        begin
            unique case (state)
                ACS_IDLE:
                begin
                    if (launch_one)
                    begin
                        state         <= ACS_ISSUE;
                        work          <= oneshot_mask;
                        kind_periodic <= 1'b0;
                    end
                    else if (launch_per)
                    begin
                        state         <= ACS_ISSUE;
                        work          <= periodic_channel_mask;
                        kind_periodic <= 1'b1;
                    end
                end
                ACS_ISSUE:
                begin
                    // Empty masks finish without touching the core.
                    if (work == 16'h0000)
                        state <= ACS_IDLE;
                    else
                    begin
                        state        <= ACS_WAIT;
                        CORE_CHANNEL <= lowest(work);
                    end
                end
                ACS_WAIT:
                begin
                    if (CORE_DONE)
                    begin
                        work  <= work & ~(16'h1 << CORE_CHANNEL);
                        state <= cycle_end ? ACS_IDLE : ACS_ISSUE;
                    end
                end
                default:
                    state <= ACS_IDLE;
            endcase
        end
    end

    // One start strobe per channel, raised as the scan enters the wait.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            CORE_START <= 1'b0;
        else
            CORE_START <= !hw_rst && state == ACS_ISSUE
                          && work != 16'h0000;
    end

    // ****************************************************************
    // Core power
    // ****************************************************************
    // Power is held on through a running cycle; between cycles it stays
    // on only when idle power-down is disabled and the converter is on.
    // Delays run with the core off, trading start latency for power.
    always_ff @(posedge MCLK or negedge RSTN)
    begin
        if (!RSTN)
            CORE_POWER <= 1'b0;
        else
            CORE_POWER <= !hw_rst && (
                state != ACS_IDLE || launch_one || launch_per
                || (ctrl[acs_pkg::CTL_ON]
                    && ctrl[acs_pkg::CTL_PDDIS]));
    end

endmodule

//--- acs_sequencer_assertions.sv
/* Port checker for the sequencer.
   Assumes it is bound to acs_sequencer, one clock, reset low. */
module acs_sequencer_chk(
    input wire logic        MCLK,
    input wire logic        RSTN,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        IRQ,
    input wire logic        CORE_RESET,
    input wire logic        CORE_POWER,
    input wire logic        CORE_START,
    input wire logic [3:0]  CORE_CHANNEL,
    input wire logic        CORE_DONE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    sequence s_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
    sequence s_ack; WB_ACK_O ##1 !WB_ACK_O; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_mask_hi; s_req ##0 (!WB_WE_I && WB_ADR_I == 8'h0C)
        |=> WB_DAT_O[31:16] == 16'h0000; endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("mask");
    property p_rst_idle; CORE_RESET |-> !CORE_START; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("rst");
    property p_rst_off; CORE_RESET [*2] |-> !CORE_POWER; endproperty
    a_rst_off: assert property (p_rst_off) else $error("pwr");
    property p_start_pwr; CORE_START |-> CORE_POWER; endproperty
    a_start_pwr: assert property (p_start_pwr) else $error("off");
    property p_gap; CORE_START |=> !CORE_START [*2]; endproperty
    a_gap: assert property (p_gap) else $error("gap");
    property p_chan; !CORE_START |-> $stable(CORE_CHANNEL); endproperty
    a_chan: assert property (p_chan) else $error("chan");
    property p_done_pwr; CORE_DONE |-> CORE_POWER; endproperty
    a_done_pwr: assert property (p_done_pwr) else $error("done");
endmodule
bind acs_sequencer acs_sequencer_chk u_chk(.MCLK(MCLK), .RSTN(RSTN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ),
    .CORE_RESET(CORE_RESET), .CORE_POWER(CORE_POWER),
    .CORE_START(CORE_START), .CORE_CHANNEL(CORE_CHANNEL),
    .CORE_DONE(CORE_DONE));

//--- acs_core_model.sv
/* Converter core model: one done pulse per start, quick or slow.
   Assumes starts come only while it is idle. */
module acs_core_model(
    input wire logic clk,
    input wire logic start,
    input wire logic slow,
    output logic     done);
    timeunit 1ns; timeprecision 1ps;
    logic [1:0] cnt = 2'h0; // Cycles left in the conversion.
    initial done = 1'b0;
    always @(posedge clk)
    begin
        done <= (cnt == 2'h1);
        cnt <= start ? (slow ? 2'h3 : 2'h1) : (cnt != 2'h0 ? cnt - 2'h1 : cnt);
    end
endmodule

//--- acs_sequencer_tb.sv
/* Scenario bench for the sequencer.
   Assumes a delay step shortened to four clock cycles. */
module acs_sequencer_tb;
    timeunit 1ns; timeprecision 1ps;
    localparam int TK = 4; // Short step keeps the run brief.
    logic mclk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF, chan;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, irq, crst, cpow, cstart, cdone, slow = 1'b0;
    int n_fail = 0, tests_run = 0, cyc_n = 0, nrst = 0, t0;
    int chq[$], tq[$]; // Channel and cycle of every start.
    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc_n <= cyc_n + 1;
        if (cstart === 1'b1)
        begin
            chq.push_back(chan);
            tq.push_back(cyc_n);
        end
        if (crst === 1'b1) nrst <= nrst + 1;
        if (cyc_n > 3000) begin n_fail++; end_of_test(); end
    end
    acs_sequencer #(.TICK_CYCLES(TK)) u_acs_sequencer(.MCLK(mclk),
        .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .IRQ(irq), .CORE_RESET(crst), .CORE_POWER(cpow),
        .CORE_START(cstart), .CORE_CHANNEL(chan), .CORE_DONE(cdone));
    acs_core_model u_acs_core_model(.clk(mclk), .start(cstart),
        .slow(slow), .done(cdone));
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0); chk(q, e);
    endtask
    task automatic st(input int n); repeat (n) @(posedge mclk); #1; endtask
    // Reset values and the width of the one-shot mask.
    task automatic t_regs;
        rd(8'h00, 32'h0); rd(8'h04, 32'h0); rd(8'h08, 32'h0);
        wb(1, 8'h0C, 32'hFFFF_0005); rd(8'h0C, 32'h5);
    endtask
    // A one-shot waits for the converter, then scans channels 0 and 2.
    task automatic t_oneshot;
        wb(1, 8'h00, 32'h2); st(20); chk(chq.size(), 0);
        wb(1, 8'h00, 32'h3); st(30); chk(nrst, 1);
        chk(chq.size() * 16 + chq[0] * 4 + chq[1], 32'h22);
        chk(cpow, 0); rd(8'h00, 32'h81);
    endtask
    // The completion event reaches the interrupt only through its mask.
    task automatic t_irq;
        st(1); chk(irq, 0); wb(1, 8'h44, 32'h1); st(1); chk(irq, 1);
        rd(8'h40, 32'h1); st(1); chk(irq, 0);
        wb(1, 8'h00, 32'h81); rd(8'h00, 32'h1);
    endtask
    // Periodic cycles: first wait, then the interval, then a clean stop.
    task automatic t_periodic;
        chq.delete(); tq.delete(); slow <= 1'b1;
        wb(1, 8'h10, 32'h2); wb(1, 8'h04, 32'h0001_0002);
        wb(1, 8'h00, 32'h5); t0 = cyc_n; st(5); chk(cpow, 0);
        st(60); chk(tq[0] - t0 inside {[2 * TK : 2 * TK + 9]}, 1);
        chk(tq[1] - tq[0] inside {[TK + 2 : TK + 14]}, 1);
        chk(chq[0], 1); rd(8'h00, 32'h45);
        wb(1, 8'h44, 32'h2); st(1); chk(irq, 1);
        wb(1, 8'h00, 32'h1); t0 = chq.size(); st(40);
        chk(chq.size() - t0 < 2, 1); chq.delete();
    endtask
    // One-shot ignores the delays; core power follows the control bits.
    task automatic t_power;
        wb(1, 8'h00, 32'h3); st(5); chk(chq.size() > 0, 1);
        st(30); wb(1, 8'h00, 32'h9); st(2); chk(cpow, 1);
        wb(1, 8'h00, 32'h0); st(2); chk(cpow, 0);
    endtask
    // Hardware reset keeps the registers; after it an empty mask completes.
    task automatic t_hwrst;
        wb(1, 8'h00, 32'h10); rd(8'h04, 32'h0001_0002);
        chk({crst, cpow}, 2'b10); rd(8'h00, 32'hD0);
        wb(1, 8'h00, 32'h0); st(2); chk(crst, 0);
        wb(1, 8'h0C, 32'h0); chq.delete(); wb(1, 8'h00, 32'h83); st(5);
        chk(chq.size(), 0); rd(8'h00, 32'hC1);
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_oneshot();
        t_irq();
        t_periodic();
        t_power();
        t_hwrst();
        end_of_test();
    end
    task automatic end_of_test;
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
endmodule
